// File: rtl/gocr_pkg.sv
// Constants, codes and states of the gyro offset and command register bank.
// Contract
// [R01] With compensation on, add each axis offset to filtered and pre-filtered rate.
// [R02] Offsets are 10-bit signed: low bytes at 0x74..0x76, high pairs at 0x77.
// [R03] Bit 7 of byte 0x77 enables compensation; clear passes rate unmodified.
// [R04] Offset unit is 0.12 deg/s times two to the range setting.
// [R05] Offsets reload from persistent memory after power-on and soft reset.
// [R06] Code 0x03 runs fast calibration; results land in the offset bytes.
// [R07] While a command runs, new command writes drop, except soft reset.
// [R08] A dropped command write sets the dropped-command flag at 0x02; a drop in the ST_BOOT cycle does not set it.
// [R09] Suspend to normal or fast start-up keeps commands busy about 55 ms.
// [R10] Soft reset with sensor restart adds 300 us start-up to switching time.
// [R11] Codes 0x14, 0x15, 0x17 set gyro power mode; 0x16 is reserved.
// [R12] Software issues 0x11 before programming memory; 0x10 returns to suspend.
// [R13] Code 0xA0 copies persistent-backed registers into persistent memory.
// [R14] Code 0xB0 empties the sample queue, leaving its settings alone.
// [R15] Code 0xB6 resets and reboots; settings return to defaults or stored values.
// [R16] Undefined command codes are ignored and do nothing.
// [R17] Command register is write-only, resets to 0x00, works in every mode.
// [R18] Memory programming needs the enable bit at 0x6A set by software.
// [R19] The reserved power code is ignored: no busy time, no error flag.
// [R20] Offset bytes stay stable while calibration or programming runs.
package gocr_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PMU_WAKE_MS = 55;
  localparam int unsigned PMU_WAKE_CYC = PMU_WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned SYS_START_US = 300;
  localparam int unsigned SYS_START_CYC = SYS_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 22;
  localparam int unsigned ADDR_W = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_ERR = 8'h02;
  localparam logic [7:0] IDX_PMU_STAT = 8'h03;
  localparam logic [7:0] IDX_CONF = 8'h6a;
  localparam logic [7:0] IDX_PSETUP = 8'h70;
  localparam logic [7:0] IDX_OFF_X = 8'h74;
  localparam logic [7:0] IDX_OFF_Y = 8'h75;
  localparam logic [7:0] IDX_OFF_Z = 8'h76;
  localparam logic [7:0] IDX_OFF_HI = 8'h77;
  localparam logic [7:0] IDX_CMD = 8'h7e;
  // Field positions.
  localparam int unsigned ERR_DROP_BIT = 6;
  localparam int unsigned CONF_PROG_BIT = 1;
  localparam int unsigned PSETUP_RANGE_LSB = 6;
  localparam int unsigned HI_EN_BIT = 7;
  localparam int unsigned HI_RSVD_BIT = 6;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_GYR_LSB = 2;
  localparam int unsigned STAT_GEN_BIT = 0;
  // Reset values.
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [7:0] OFF_RST = 8'h00;
  localparam logic [1:0] RANGE_RST = 2'h0;
  // Command codes.
  localparam logic [7:0] CMD_FOC = 8'h03;
  localparam logic [7:0] CMD_GEN_SUSP = 8'h10;
  localparam logic [7:0] CMD_GEN_NORM = 8'h11;
  localparam logic [7:0] CMD_GYR_SUSP = 8'h14;
  localparam logic [7:0] CMD_GYR_NORM = 8'h15;
  localparam logic [7:0] CMD_GYR_FSUP = 8'h17;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_FLUSH = 8'hb0;
  localparam logic [7:0] CMD_SRST = 8'hb6;
  localparam logic [1:0] PMU_SUSPEND = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TIMER = 3'b001,
    ST_FOC = 3'b010,
    ST_NVM = 3'b011,
    ST_SRST = 3'b100,
    ST_BOOT = 3'b101
  } gocr_state_t;
endpackage

// File: rtl/gocr_regs.sv
// Gyro offset compensation and command register bank behind an APB slave.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module gocr_regs #(
  parameter int unsigned DW = 16,
  parameter int unsigned WAKE_CYC = gocr_pkg::PMU_WAKE_CYC,
  parameter int unsigned START_CYC = gocr_pkg::SYS_START_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gocr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3*DW-1:0] rate_filt_in,
  input wire logic [3*DW-1:0] rate_pre_in,
  output logic [3*DW-1:0] rate_filt_out,
  output logic [3*DW-1:0] rate_pre_out,
  input wire logic [31:0] nvm_offset_image,
  input wire logic [7:0] nvm_setup_image,
  output logic nvm_prog_start,
  output logic [31:0] nvm_offset_data,
  output logic [7:0] nvm_setup_data,
  input wire logic nvm_done,
  output logic foc_start,
  input wire logic foc_done,
  input wire logic [29:0] foc_result,
  output logic fifo_flush,
  output logic [1:0] gyr_pmu_mode,
  output logic gen_pmu_normal,
  output logic cmd_busy
);
  localparam int unsigned TW = gocr_pkg::TIMER_W;

  initial
  begin
    if (DW < 13 || WAKE_CYC < 1 || START_CYC < 1 ||
        WAKE_CYC + START_CYC >= (1 << TW))
      $error("gocr_regs: parameter out of range");
  end

  gocr_pkg::gocr_state_t state_ff, nxt_state;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic [7:0] off_lo_ff [3];
  logic [7:0] off_hi_ff;
  logic [1:0] range_ff;
  logic [7:0] conf_ff;
  logic drop_err_ff;
  logic [1:0] gyr_mode_ff;
  logic gen_mode_ff;
  logic foc_start_ff, nvm_prog_ff, fifo_flush_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;
  logic [DW-1:0] filt_ff [3];
  logic [DW-1:0] pre_ff [3];

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = idx == gocr_pkg::IDX_ERR || idx == gocr_pkg::IDX_PMU_STAT ||
      idx == gocr_pkg::IDX_CONF || idx == gocr_pkg::IDX_PSETUP ||
      idx == gocr_pkg::IDX_OFF_X || idx == gocr_pkg::IDX_OFF_Y ||
      idx == gocr_pkg::IDX_OFF_Z || idx == gocr_pkg::IDX_OFF_HI ||
      idx == gocr_pkg::IDX_CMD;
  endfunction

  function automatic logic is_defined(input logic [7:0] c);
    is_defined = c == gocr_pkg::CMD_FOC || c == gocr_pkg::CMD_GEN_SUSP ||
      c == gocr_pkg::CMD_GEN_NORM || c == gocr_pkg::CMD_GYR_SUSP ||
      c == gocr_pkg::CMD_GYR_NORM || c == gocr_pkg::CMD_GYR_FSUP ||
      c == gocr_pkg::CMD_PROG || c == gocr_pkg::CMD_FLUSH ||
      c == gocr_pkg::CMD_SRST;
  endfunction

  // Offset scaled to rate units: sign extended, then shifted by range.
  function automatic logic [DW-1:0] scaled(input logic [9:0] v,
                                          input logic [1:0] r);
    logic [DW-1:0] e;
    e = {{(DW-10){v[9]}}, v};
    scaled = e << r;
  endfunction

  wire logic [7:0] idx = paddr[gocr_pkg::ADDR_W-1:2];
  wire logic apb_setup = psel && !penable;
  wire logic apb_acc = psel && penable;
  wire logic apb_wr = apb_acc && pwrite && is_mapped(idx);
  wire logic cmd_wr = apb_wr && idx == gocr_pkg::IDX_CMD;
  wire logic [7:0] code = pwdata[7:0];
  wire logic srst = cmd_wr && code == gocr_pkg::CMD_SRST;
  wire logic accept = cmd_wr && is_defined(code) &&
    (state_ff == gocr_pkg::ST_IDLE || srst);
  wire logic drop = cmd_wr && is_defined(code) &&
    state_ff != gocr_pkg::ST_IDLE && !srst;
  wire logic boot = state_ff == gocr_pkg::ST_BOOT;
  wire logic off_frozen = state_ff == gocr_pkg::ST_FOC ||
    state_ff == gocr_pkg::ST_NVM;
  wire logic foc_finish = state_ff == gocr_pkg::ST_FOC && foc_done && !srst;
  wire logic comp_en = off_hi_ff[gocr_pkg::HI_EN_BIT];

  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = slverr_ff;
  assign foc_start = foc_start_ff;
  assign nvm_prog_start = nvm_prog_ff;
  assign fifo_flush = fifo_flush_ff;
  assign gyr_pmu_mode = gyr_mode_ff;
  assign gen_pmu_normal = gen_mode_ff;
  assign cmd_busy = state_ff != gocr_pkg::ST_IDLE;
  assign nvm_offset_data = {off_hi_ff, off_lo_ff[2], off_lo_ff[1],
                            off_lo_ff[0]};
  assign nvm_setup_data = {range_ff, 6'h00};

  // Command sequencer; soft reset preempts whatever is running.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    if (srst)
    begin
      nxt_state = gocr_pkg::ST_SRST;
      nxt_timer = TW'(START_CYC - 1); // [R15]
      if (gyr_mode_ff != gocr_pkg::PMU_SUSPEND)
        nxt_timer = TW'(START_CYC + WAKE_CYC - 1); // [R10]
    end
    else
    begin
      unique case (state_ff)
        gocr_pkg::ST_IDLE:
        begin
          if (accept)
          begin
            nxt_state = gocr_pkg::ST_TIMER;
            nxt_timer = '0;
            if (code == gocr_pkg::CMD_FOC)
              nxt_state = gocr_pkg::ST_FOC; // [R06]
            else if (code == gocr_pkg::CMD_PROG &&
                     conf_ff[gocr_pkg::CONF_PROG_BIT])
              nxt_state = gocr_pkg::ST_NVM; // [R13] [R18]
            else if ((code == gocr_pkg::CMD_GYR_NORM ||
                      code == gocr_pkg::CMD_GYR_FSUP) &&
                     gyr_mode_ff == gocr_pkg::PMU_SUSPEND)
              nxt_timer = TW'(WAKE_CYC - 1); // [R09]
          end
        end
        gocr_pkg::ST_TIMER, gocr_pkg::ST_SRST:
        begin
          if (timer_ff == '0)
            nxt_state = (state_ff == gocr_pkg::ST_SRST) ?
              gocr_pkg::ST_BOOT : gocr_pkg::ST_IDLE;
          else
            nxt_timer = timer_ff - 1'b1;
        end
        gocr_pkg::ST_FOC:
          if (foc_done)
            nxt_state = gocr_pkg::ST_IDLE;
        gocr_pkg::ST_NVM:
          if (nvm_done)
            nxt_state = gocr_pkg::ST_IDLE;
        gocr_pkg::ST_BOOT:
          nxt_state = gocr_pkg::ST_IDLE;
        default:
          nxt_state = gocr_pkg::ST_BOOT;
      endcase
    end
  end

  // Power-on goes through the boot state so the stored offsets get loaded.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= gocr_pkg::ST_BOOT; // [R05]
      timer_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state; // [R07]
      timer_ff <= nxt_timer;
    end
  end

  // One-cycle command strobes toward the sensor core.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      foc_start_ff <= 1'b0;
      nvm_prog_ff <= 1'b0;
      fifo_flush_ff <= 1'b0;
    end
    else
    begin
      foc_start_ff <= accept && code == gocr_pkg::CMD_FOC; // [R06]
      nvm_prog_ff <= accept && code == gocr_pkg::CMD_PROG &&
        conf_ff[gocr_pkg::CONF_PROG_BIT]; // [R13]
      fifo_flush_ff <= accept && code == gocr_pkg::CMD_FLUSH; // [R14]
    end
  end

  // Power modes; the reserved code never reaches here as it is undefined.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gyr_mode_ff <= gocr_pkg::PMU_SUSPEND;
      gen_mode_ff <= 1'b0;
    end
    else if (boot)
    begin
      gyr_mode_ff <= gocr_pkg::PMU_SUSPEND; // [R15]
      gen_mode_ff <= 1'b0;
    end
    else if (accept && code[7:2] == gocr_pkg::CMD_GYR_SUSP[7:2])
      gyr_mode_ff <= code[1:0]; // [R11] [R19]
    else if (accept && code[7:1] == gocr_pkg::CMD_GEN_SUSP[7:1])
      gen_mode_ff <= code[0]; // [R12]
  end

  // Offset bytes: boot load, calibration result, then software writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int a = 0; a < 3; a++)
        off_lo_ff[a] <= gocr_pkg::OFF_RST;
      off_hi_ff <= gocr_pkg::OFF_RST;
      range_ff <= gocr_pkg::RANGE_RST;
    end
    else if (boot)
    begin
      for (int a = 0; a < 3; a++)
        off_lo_ff[a] <= nvm_offset_image[8*a +: 8]; // [R05]
      off_hi_ff <= nvm_offset_image[31:24] &
        ~(8'h01 << gocr_pkg::HI_RSVD_BIT);
      range_ff <= nvm_setup_image[gocr_pkg::PSETUP_RANGE_LSB +: 2];
    end
    else if (foc_finish)
    begin
      for (int a = 0; a < 3; a++)
      begin
        off_lo_ff[a] <= foc_result[10*a +: 8]; // [R06]
        off_hi_ff[2*a +: 2] <= foc_result[10*a+8 +: 2];
      end
    end
    else if (apb_wr && !off_frozen)
    begin
      // Calibration and programming own the bytes while they run.
      for (int a = 0; a < 3; a++)
        if (idx == gocr_pkg::IDX_OFF_X + 8'(a))
          off_lo_ff[a] <= pwdata[7:0]; // [R02] [R20]
      if (idx == gocr_pkg::IDX_OFF_HI)
        off_hi_ff <= pwdata[7:0] & ~(8'h01 << gocr_pkg::HI_RSVD_BIT);
      if (idx == gocr_pkg::IDX_PSETUP)
        range_ff <= pwdata[gocr_pkg::PSETUP_RANGE_LSB +: 2]; // [R04]
    end
  end

  // Configuration and the dropped-command flag; a new drop beats read-clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conf_ff <= gocr_pkg::CONF_RST;
      drop_err_ff <= 1'b0;
    end
    else if (boot)
    begin
      conf_ff <= gocr_pkg::CONF_RST;
      drop_err_ff <= 1'b0;
    end
    else
    begin
      if (apb_wr && idx == gocr_pkg::IDX_CONF)
        conf_ff <= pwdata[7:0] & (8'h01 << gocr_pkg::CONF_PROG_BIT);
      if (drop)
        drop_err_ff <= 1'b1; // [R08]
      else if (apb_acc && !pwrite && idx == gocr_pkg::IDX_ERR)
        drop_err_ff <= 1'b0;
    end
  end

  // Read data is captured in the setup phase so the access needs no wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= '0;
      slverr_ff <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_ff <= '0;
      slverr_ff <= !is_mapped(idx);
      unique case (idx)
        gocr_pkg::IDX_ERR:
          prdata_ff[gocr_pkg::ERR_DROP_BIT] <= drop_err_ff;
        gocr_pkg::IDX_PMU_STAT:
          prdata_ff[7:0] <= {cmd_busy, 3'h0, gyr_mode_ff, 1'b0, gen_mode_ff};
        gocr_pkg::IDX_CONF:
          prdata_ff[7:0] <= conf_ff;
        gocr_pkg::IDX_PSETUP:
          prdata_ff[7:0] <= nvm_setup_data;
        gocr_pkg::IDX_OFF_X, gocr_pkg::IDX_OFF_Y, gocr_pkg::IDX_OFF_Z:
          prdata_ff[7:0] <= off_lo_ff[idx[1:0]];
        gocr_pkg::IDX_OFF_HI:
          prdata_ff[7:0] <= off_hi_ff;
        default:
          prdata_ff <= '0; // [R17]
      endcase
    end
  end

  // Rate path; the sum wraps, so large offsets at wide range can overflow.
  for (genvar a = 0; a < 3; a++)
  begin : g_axis
    wire logic [9:0] off = {off_hi_ff[2*a +: 2], off_lo_ff[a]};
    wire logic [DW-1:0] add = comp_en ? scaled(off, range_ff) : '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        filt_ff[a] <= '0;
        pre_ff[a] <= '0;
      end
      else
      begin
        filt_ff[a] <= rate_filt_in[DW*a +: DW] + add; // [R01] [R03]
        pre_ff[a] <= rate_pre_in[DW*a +: DW] + add; // [R01] [R04]
      end
    end
    assign rate_filt_out[DW*a +: DW] = filt_ff[a];
    assign rate_pre_out[DW*a +: DW] = pre_ff[a];
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_drop_sets_flag: assert property (drop |=> drop_err_ff) // [R08]
    else $error("dropped command did not set the flag");
  a_drop_no_effect: assert property (drop |=> !foc_start_ff && !nvm_prog_ff
    && !fifo_flush_ff && $stable(gyr_mode_ff)) // [R07]
    else $error("dropped command had an effect");
  a_foc_starts: assert property (accept && code == gocr_pkg::CMD_FOC && !srst
    |=> s_one_pulse(foc_start_ff) and state_ff == gocr_pkg::ST_FOC) // [R06]
    else $error("calibration did not start");
  a_foc_result_in: assert property (foc_finish |=> off_lo_ff[1] ==
    $past(foc_result[17:10]) && off_hi_ff[5:4] == $past(foc_result[29:28]))
    else $error("calibration result not stored"); // [R06]
  a_offs_frozen: assert property (off_frozen && !nxt_state[2] &&
    !foc_finish |=> $stable(off_lo_ff[0]) && $stable(off_hi_ff))
    else $error("offsets moved while frozen"); // [R20]
  a_wake_busy: assert property (accept && code == gocr_pkg::CMD_GYR_NORM &&
    gyr_mode_ff == gocr_pkg::PMU_SUSPEND |=> timer_ff == TW'(WAKE_CYC - 1)
    && state_ff == gocr_pkg::ST_TIMER) // [R09]
    else $error("wake-up busy time not loaded");
  a_undef_ignored: assert property (cmd_wr && !is_defined(code) &&
    state_ff == gocr_pkg::ST_IDLE && !drop_err_ff |=>
    state_ff == gocr_pkg::ST_IDLE && !drop_err_ff) // [R16]
    else $error("undefined command acted");
  a_srst_reboot: assert property (srst |=> state_ff == gocr_pkg::ST_SRST)
    else $error("soft reset not taken"); // [R15]
  a_boot_loads: assert property (boot |=> off_lo_ff[2] ==
    $past(nvm_offset_image[23:16])) // [R05]
    else $error("boot did not load offsets");
  a_rate_bypass: assert property (!comp_en |=> filt_ff[0] ==
    $past(rate_filt_in[DW-1:0])) // [R03]
    else $error("rate modified with compensation off");
  a_flush_pulse: assert property (accept && code == gocr_pkg::CMD_FLUSH &&
    !srst |=> s_one_pulse(fifo_flush_ff)) // [R14]
    else $error("flush strobe wrong");
  a_prog_gated: assert property (accept && code == gocr_pkg::CMD_PROG &&
    !conf_ff[gocr_pkg::CONF_PROG_BIT] |=> !nvm_prog_ff) // [R13]
    else $error("programming without enable");
endmodule
`default_nettype wire

// File: verification/gyro_offset_and_command_regs_test.sv
// Self-checking testbench for the gyro offset and command register bank.
`timescale 1ns/100ps
`default_nettype none
module gyro_offset_and_command_regs_test;
  localparam int unsigned DW = 16;
  localparam int unsigned WK = 20;
  localparam int unsigned ST = 10;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [47:0] rate_filt_in = 48'h0300_0200_0100;
  logic [47:0] rate_pre_in = 48'h0030_0020_0010;
  logic [47:0] rate_filt_out;
  logic [47:0] rate_pre_out;
  logic [31:0] nvm_offset_image = 32'h2511_2233;
  logic [7:0] nvm_setup_image = 8'h40;
  logic nvm_prog_start;
  logic [31:0] nvm_offset_data;
  logic [7:0] nvm_setup_data;
  logic nvm_done = 1'b0;
  logic foc_start;
  logic foc_done = 1'b0;
  logic [29:0] foc_result = 30'h0000_0000;
  logic fifo_flush;
  logic [1:0] gyr_pmu_mode;
  logic gen_pmu_normal;
  logic cmd_busy;
  int n_fail = 0;
  int checks = 0;

  always #10 pclk = ~pclk;

  gocr_regs #(.DW(DW), .WAKE_CYC(WK), .START_CYC(ST)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rate_filt_in(rate_filt_in),
    .rate_pre_in(rate_pre_in), .rate_filt_out(rate_filt_out),
    .rate_pre_out(rate_pre_out), .nvm_offset_image(nvm_offset_image),
    .nvm_setup_image(nvm_setup_image), .nvm_prog_start(nvm_prog_start),
    .nvm_offset_data(nvm_offset_data), .nvm_setup_data(nvm_setup_data),
    .nvm_done(nvm_done), .foc_start(foc_start), .foc_done(foc_done),
    .foc_result(foc_result), .fifo_flush(fifo_flush),
    .gyr_pmu_mode(gyr_pmu_mode), .gen_pmu_normal(gen_pmu_normal),
    .cmd_busy(cmd_busy)
  );

  task automatic stop_test;
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask

  // One APB transfer; it returns at the access edge, request released.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp,
                     input logic [31:0] mask, input string msg);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk((rd & mask) === (exp & mask) && err === 1'b0, msg);
  endtask

  // Call one step after the command edge; counts busy cycles, bounded.
  task automatic wait_idle(output int n);
    n = 0;
    while (cmd_busy === 1'b1 && n < 5000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic t_boot;
    chk(cmd_busy === 1'b0 && gyr_pmu_mode === 2'b00, "idle after boot");
    rdc(gocr_pkg::IDX_OFF_X, 32'h33, ALL, "boot x low");
    rdc(gocr_pkg::IDX_OFF_Y, 32'h22, ALL, "boot y low");
    rdc(gocr_pkg::IDX_OFF_Z, 32'h11, ALL, "boot z low");
    rdc(gocr_pkg::IDX_OFF_HI, 32'h25, ALL, "boot high");
    rdc(gocr_pkg::IDX_PSETUP, 32'h40, 32'hc0, "boot range");
    rdc(gocr_pkg::IDX_CMD, 32'h00, ALL, "command reads zero");
  endtask

  task automatic t_offset;
    wr(gocr_pkg::IDX_PSETUP, 8'h80);
    #1;
    chk(nvm_setup_data === 8'h80, "range image");
    wr(gocr_pkg::IDX_OFF_X, 8'hfd);
    wr(gocr_pkg::IDX_OFF_Y, 8'h05);
    wr(gocr_pkg::IDX_OFF_Z, 8'h00);
    wr(gocr_pkg::IDX_OFF_HI, 8'hd3);
    rdc(gocr_pkg::IDX_OFF_HI, 32'h93, ALL, "high byte");
    repeat (3) @(posedge pclk);
    #1;
    chk(rate_filt_out[15:0] === 16'h0100 - 16'd12, "x filt");
    chk(rate_filt_out[31:16] === 16'h0200 + 16'd20, "y filt");
    chk(rate_filt_out[47:32] === 16'h0300 + 16'd1024, "z filt");
    chk(rate_pre_out[15:0] === 16'h0010 - 16'd12, "x pre");
    chk(rate_pre_out[47:32] === 16'h0030 + 16'd1024, "z pre");
    wr(gocr_pkg::IDX_PSETUP, 8'h00);
    repeat (3) @(posedge pclk);
    #1;
    chk(rate_filt_out[15:0] === 16'h0100 - 16'd3, "x unit");
    wr(gocr_pkg::IDX_OFF_HI, 8'h13);
    repeat (3) @(posedge pclk);
    #1;
    chk(rate_filt_out === rate_filt_in, "filt off");
    chk(rate_pre_out === rate_pre_in, "pre off");
    wr(gocr_pkg::IDX_OFF_HI, 8'h93);
  endtask

  task automatic t_short;
    logic [7:0] bad [3];
    int n;
    bad = '{8'h16, 8'h55, 8'hff};
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_FLUSH);
    #1;
    chk(fifo_flush === 1'b1 && cmd_busy === 1'b1, "flush strobe");
    @(posedge pclk);
    #1;
    chk(fifo_flush === 1'b0, "flush one cycle");
    wait_idle(n);
    foreach (bad[i])
    begin
      wr(gocr_pkg::IDX_CMD, bad[i]);
      #1;
      chk(cmd_busy === 1'b0 && fifo_flush === 1'b0, "undefined");
      chk(gyr_pmu_mode === 2'b00 && foc_start === 1'b0, "no effect");
    end
    rdc(gocr_pkg::IDX_ERR, 32'h00, 32'h40, "no drop flag");
  endtask

  task automatic t_pmu;
    int n;
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GYR_NORM);
    #1;
    wait_idle(n);
    chk(n >= WK && n <= WK + 3, "wake busy time");
    chk(gyr_pmu_mode === 2'b01, "gyro normal");
    rdc(gocr_pkg::IDX_PMU_STAT, 32'h04, 32'h0c, "status mode");
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GYR_FSUP);
    #1;
    wait_idle(n);
    chk(n <= 3 && gyr_pmu_mode === 2'b11, "fast start-up");
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GYR_SUSP);
    #1;
    wait_idle(n);
    chk(gyr_pmu_mode === 2'b00, "gyro suspend");
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GEN_NORM);
    #1;
    wait_idle(n);
    chk(gen_pmu_normal === 1'b1, "general normal");
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GEN_SUSP);
    #1;
    wait_idle(n);
    chk(gen_pmu_normal === 1'b0, "general suspend");
  endtask

  task automatic t_foc;
    int n;
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_FOC);
    #1;
    chk(foc_start === 1'b1 && cmd_busy === 1'b1, "foc start");
    wr(gocr_pkg::IDX_OFF_X, 8'h77);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GYR_NORM);
    #1;
    chk(gyr_pmu_mode === 2'b00 && cmd_busy === 1'b1, "dropped");
    rdc(gocr_pkg::IDX_OFF_X, 32'hfd, ALL, "offset held");
    rdc(gocr_pkg::IDX_ERR, 32'h40, 32'h40, "drop flag set");
    rdc(gocr_pkg::IDX_ERR, 32'h00, 32'h40, "drop flag cleared");
    @(posedge pclk);
    foc_result <= {10'h055, 10'h2aa, 10'h123};
    foc_done <= 1'b1;
    @(posedge pclk);
    foc_done <= 1'b0;
    #1;
    wait_idle(n);
    rdc(gocr_pkg::IDX_OFF_X, 32'h23, ALL, "foc x");
    rdc(gocr_pkg::IDX_OFF_Y, 32'haa, ALL, "foc y");
    rdc(gocr_pkg::IDX_OFF_Z, 32'h55, ALL, "foc z");
    rdc(gocr_pkg::IDX_OFF_HI, 32'h09, 32'h3f, "foc high");
  endtask

  task automatic t_nvm;
    int n;
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_PROG);
    #1;
    chk(nvm_prog_start === 1'b0, "no program unless enabled");
    wait_idle(n);
    wr(gocr_pkg::IDX_CONF, 8'h02);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GEN_NORM);
    #1;
    wait_idle(n);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_PROG);
    #1;
    chk(nvm_prog_start === 1'b1 && cmd_busy === 1'b1, "program");
    chk(nvm_offset_data[29:0] === 30'h0955_aa23, "image data");
    @(posedge pclk);
    nvm_done <= 1'b1;
    @(posedge pclk);
    nvm_done <= 1'b0;
    #1;
    wait_idle(n);
    chk(cmd_busy === 1'b0, "program done");
  endtask

  task automatic t_srst;
    int n;
    wr(gocr_pkg::IDX_OFF_X, 8'h5a);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_GYR_NORM);
    #1;
    wait_idle(n);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_FOC);
    wr(gocr_pkg::IDX_CMD, gocr_pkg::CMD_SRST);
    #1;
    chk(cmd_busy === 1'b1, "soft reset taken while busy");
    wait_idle(n);
    chk(n >= ST + WK && n <= ST + WK + 4, "restart time");
    chk(gyr_pmu_mode === 2'b00, "mode default");
    rdc(gocr_pkg::IDX_OFF_X, 32'h33, ALL, "reload x");
    rdc(gocr_pkg::IDX_OFF_HI, 32'h25, ALL, "reload high");
    rdc(gocr_pkg::IDX_CONF, 32'h00, 32'h02, "conf default");
    rdc(gocr_pkg::IDX_ERR, 32'h00, 32'h40, "soft reset not dropped");
  endtask

  task automatic t_unmapped;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 8'h50, 8'hab, rd, err);
    chk(err === 1'b1, "unmapped write error");
    apb(1'b0, 8'h50, 8'h00, rd, err);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    t_boot();
    t_offset();
    t_short();
    t_pmu();
    t_foc();
    t_nvm();
    t_srst();
    t_unmapped();
    stop_test();
  end

  // The whole run needs well under ten thousand cycles.
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
